// *** rtl/qcm_map.svh ***
/*
  register offsets, field positions, reset values and timing values in ns of the
  quadrature counter module.
  assumes a 40 MHz module clock and word-indexed register addresses.
*/
`ifndef QCM_MAP_SVH
`define QCM_MAP_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define QCM_REG_SETUP1    5'h00
`define QCM_REG_SETUP2    5'h01
`define QCM_REG_DISP_CH1  5'h02
`define QCM_REG_SETUP3    5'h03
`define QCM_REG_DISP_CH2  5'h04
`define QCM_REG_DISP_CH3  5'h05
`define QCM_REG_DISP_CH4  5'h06
`define QCM_REG_SETPT5    5'h07
`define QCM_REG_SETPT6    5'h08
`define QCM_REG_PRESET    5'h09
`define QCM_REG_PRIMARY   5'h0a
`define QCM_REG_SECONDARY 5'h0b
`define QCM_REG_CAP_PRI   5'h0c
`define QCM_REG_CAP_SEC   5'h0d
`define QCM_REG_GATE      5'h0e
`define QCM_REG_C_COUNT   5'h0f
`define QCM_REG_RATE_A    5'h10
`define QCM_REG_RATE_B    5'h11

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define QCM_S1_AB_LSB     0
`define QCM_S1_C_LSB      3
`define QCM_S1_CH_LSB     6
`define QCM_S2_SRC_LSB    0
`define QCM_S2_NC_LSB     4
`define QCM_S3_DEB_BIT    0
`define QCM_S3_RATE_BIT   1
`define QCM_SETUP_RST     32'h0000_0000
`define QCM_COUNT_RST     32'h0000_0000

// ****************************************************************
// timing
// ****************************************************************
`define QCM_CLK_PERIOD_NS 25
`define QCM_DEB_TIME_NS   500000
`define QCM_RLY_TIME_NS   1000000
`define QCM_RATE_TIME_NS  1000000000

`endif

// *** rtl/qcm_pkg.sv ***
/*
  types of the quadrature counter module.
  assumes qcm_map.svh for all numeric constants.
*/
package qcm_pkg;

  // ****************************************************************
  // data and mode types
  // ****************************************************************
  typedef logic [31:0] qcm_word_type;
  typedef logic [4:0]  qcm_addr_type;

  typedef enum logic [2:0] {
    QCM_AB_QUAD_X1 = 3'b000,
    QCM_AB_QUAD_X2 = 3'b001,
    QCM_AB_QUAD_X4 = 3'b010,
    QCM_AB_SUM     = 3'b011,
    QCM_AB_DIFF    = 3'b100,
    QCM_AB_INDEP   = 3'b101,
    QCM_AB_DIR     = 3'b110
  } qcm_ab_mode_type;

  typedef enum logic [2:0] {
    QCM_C_NONE    = 3'b000,
    QCM_C_CAPTURE = 3'b001,
    QCM_C_GATE    = 3'b010,
    QCM_C_ZERO    = 3'b011,
    QCM_C_PRESET  = 3'b100,
    QCM_C_START   = 3'b101,
    QCM_C_COUNT   = 3'b110
  } qcm_c_role_type;

endpackage

// *** rtl/qcm_in_if.sv ***
/*
  conditioned input levels and edges passed from the input conditioner to
  the counter core.
  assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface qcm_in_if;
  logic [2:0] level;   // filtered a, b, c
  logic [2:0] rise;    // one-cycle rising edge pulses
  logic [2:0] fall;    // one-cycle falling edge pulses
  logic       deb_en;  // low-pass filter enable
  modport cond (output level, output rise, output fall, input deb_en);
  modport core (input level, input rise, input fall, output deb_en);
endinterface

`default_nettype wire

// *** rtl/qcm_cond.sv ***
/*
  input conditioner: synchronises the a, b, c pins, optionally filters
  them and produces edge pulses.
  assumes asynchronous pins and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module qcm_cond #(
  parameter int unsigned DEB_CYCLES = 1
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  // pins
  input  wire logic [2:0] pins_i,
  // conditioned outputs
  qcm_in_if.cond          io
);
  import qcm_pkg::*;

  typedef struct packed {
    logic [2:0]       s1;
    logic [2:0]       s2;
    logic [2:0]       s3;
    logic [2:0]       filt;
    logic [2:0]       rise;
    logic [2:0]       fall;
    logic [2:0][31:0] cnt;
  } qcm_cond_state_type;

  qcm_cond_state_type r;
  qcm_cond_state_type d;

  // three-flop chain, optional stable-time filter, edge detect
  always_comb begin
    d      = r;
    d.s1   = pins_i;
    d.s2   = r.s1;
    d.s3   = r.s2;
    for (int i = 0; i < 3; i++) begin
      if (r.s2[i] != r.s3[i] || r.s3[i] == r.filt[i]) begin
        d.cnt[i] = 32'h0;                        // not settled or unchanged
      end else if (!io.deb_en) begin
        d.filt[i] = r.s3[i];
        d.cnt[i]  = 32'h0;
      end else if (r.cnt[i] >= DEB_CYCLES - 1) begin
        d.filt[i] = r.s3[i];
        d.cnt[i]  = 32'h0;
      end else begin
        d.cnt[i] = r.cnt[i] + 32'h1;
      end
    end
    d.rise = d.filt & ~r.filt;
    d.fall = ~d.filt & r.filt;
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= d;
    end
  end

  assign io.level = r.filt;
  assign io.rise  = r.rise;
  assign io.fall  = r.fall;

endmodule // qcm_cond

`default_nettype wire

// *** rtl/qcm_top.sv ***
/*
  quadrature counter module: a, b, c pulse counting with quadrature,
  combined and independent modes, c control roles, display routing,
  two setpoint relays and a rate option, set up over a register port.
  assumes a 40 MHz clock, synchronous active-low reset and a master that
  never issues read and write strobes together.

*/
`timescale 1ns/1ps
`default_nettype none
`include "qcm_map.svh"

module qcm_top #(
  parameter int unsigned DEB_CYCLES  =
    (`QCM_DEB_TIME_NS + `QCM_CLK_PERIOD_NS - 1) / `QCM_CLK_PERIOD_NS,
  parameter int unsigned RLY_CYCLES  =
    (`QCM_RLY_TIME_NS + `QCM_CLK_PERIOD_NS - 1) / `QCM_CLK_PERIOD_NS,
  parameter int unsigned RATE_CYCLES =
    `QCM_RATE_TIME_NS / `QCM_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_n_i,
  // encoder pins
  input  wire logic                 enc_a_i,
  input  wire logic                 enc_b_i,
  input  wire logic                 enc_c_i,
  // register port
  input  wire qcm_pkg::qcm_addr_type addr_i,
  input  wire qcm_pkg::qcm_word_type wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output qcm_pkg::qcm_word_type      rdata_o,
  // relays
  output logic                      relay_one_output_o,
  output logic                      relay_two_output_o
);
  import qcm_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    qcm_word_type       setup1;
    qcm_word_type       setup2;
    qcm_word_type       setup3;
    qcm_word_type       setpt5;
    qcm_word_type       setpt6;
    qcm_word_type       preset;
    qcm_word_type       prim;
    qcm_word_type       sec;
    qcm_word_type       cap_p;
    qcm_word_type       cap_s;
    qcm_word_type       gate;
    qcm_word_type       ccnt;
    logic               run;
    qcm_word_type       rate_tmr;
    qcm_word_type       rate_a_cnt;
    qcm_word_type       rate_b_cnt;
    qcm_word_type       rate_a;
    qcm_word_type       rate_b;
    logic [1:0]         rly_on;
    logic [1:0][31:0]   rly_tmr;
    qcm_word_type       rdata;
  } qcm_state_type;

  qcm_state_type r;
  qcm_state_type d;

  // ****************************************************************
  // input conditioning
  // ****************************************************************
  qcm_in_if in_if ();

  qcm_cond #(
    .DEB_CYCLES (DEB_CYCLES)
  ) u_cond (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .pins_i    ({enc_c_i, enc_b_i, enc_a_i}),
    .io        (in_if)
  );

  // filter switch from the third setup register
  assign in_if.deb_en = r.setup3[`QCM_S3_DEB_BIT];

  // ****************************************************************
  // helpers
  // ****************************************************************
  // add a small signed step with 32-bit wrap
  function automatic qcm_word_type add_step(input qcm_word_type v,
                                            input logic signed [2:0] s);
    add_step = v + {{29{s[2]}}, s};
  endfunction

  // pick one of the four output-map counters
  function automatic qcm_word_type pick(input logic [1:0] sel,
                                        input qcm_state_type st);
    case (sel)
      2'h0:    pick = st.prim;
      2'h1:    pick = st.sec;
      2'h2:    pick = st.cap_p;
      default: pick = st.gate;
    endcase
  endfunction

  // ****************************************************************
  // decoded controls
  // ****************************************************************
  qcm_ab_mode_type ab_mode;
  qcm_c_role_type  c_role;
  logic            a_lvl;
  logic            b_lvl;
  logic            c_lvl;
  logic            a_rise;
  logic            a_fall;
  logic            b_rise;
  logic            b_fall;
  logic            c_rise;
  logic            c_fall;

  assign ab_mode = qcm_ab_mode_type'(r.setup1[`QCM_S1_AB_LSB +: 3]);
  assign c_role  = qcm_c_role_type'(r.setup1[`QCM_S1_C_LSB +: 3]);
  assign a_lvl   = in_if.level[0];
  assign b_lvl   = in_if.level[1];
  assign c_lvl   = in_if.level[2];
  assign a_rise  = in_if.rise[0];
  assign a_fall  = in_if.fall[0];
  assign b_rise  = in_if.rise[1];
  assign b_fall  = in_if.fall[1];
  assign c_rise  = in_if.rise[2];
  assign c_fall  = in_if.fall[2];

  // ****************************************************************
  // counting steps per a/b mode
  // ****************************************************************
  logic signed [2:0] p_step;
  logic signed [2:0] s_step;

  // signed step applied to primary and secondary this cycle
  always_comb begin
    p_step = 3'sd0;
    s_step = 3'sd0;
    case (ab_mode)
      QCM_AB_QUAD_X1: begin
        if (a_rise && !b_lvl) p_step = -3'sd1;
        if (a_fall && !b_lvl) p_step = 3'sd1;
      end
      QCM_AB_QUAD_X2: begin
        if (a_rise) p_step = b_lvl ? 3'sd1 : -3'sd1;
        if (a_fall) p_step = b_lvl ? -3'sd1 : 3'sd1;
      end
      QCM_AB_QUAD_X4: begin
        if (a_rise) p_step = b_lvl ? 3'sd1 : -3'sd1;
        if (a_fall) p_step = b_lvl ? -3'sd1 : 3'sd1;
        if (b_rise) p_step = a_lvl ? -3'sd1 : 3'sd1;
        if (b_fall) p_step = a_lvl ? 3'sd1 : -3'sd1;
      end
      QCM_AB_SUM: begin
        p_step = $signed({2'b00, a_rise}) + $signed({2'b00, b_rise});
      end
      QCM_AB_DIFF: begin
        p_step = $signed({2'b00, a_rise}) - $signed({2'b00, b_rise});
      end
      QCM_AB_INDEP: begin
        p_step = $signed({2'b00, a_rise});
        s_step = $signed({2'b00, b_rise});
      end
      QCM_AB_DIR: begin
        if (a_rise) p_step = b_lvl ? -3'sd1 : 3'sd1;
      end
      default: begin
        p_step = 3'sd0;
        s_step = 3'sd0;
      end
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  logic       count_en;
  logic [1:0] rly_want;

  always_comb begin
    d = r;

    // gate role lets counts through only while c is high
    count_en = r.run && (c_role != QCM_C_GATE || c_lvl);

    // primary and secondary counters
    if (count_en) begin
      d.prim = add_step(r.prim, p_step);
      d.sec  = add_step(r.sec, s_step);
    end

    // gate counter collects counts of each gate window
    if (c_role == QCM_C_GATE) begin
      if (c_rise) begin
        d.gate = `QCM_COUNT_RST;
      end else if (c_lvl) begin
        d.gate = add_step(r.gate, p_step);
      end
    end

    // c is always counted in its own chain
    if (c_rise) begin
      d.ccnt = r.ccnt + 32'h1;
    end

    // c falling edge acts by role; standalone role does nothing here
    if (c_fall) begin
      case (c_role)
        QCM_C_CAPTURE: begin
          d.cap_p = r.prim;
          d.cap_s = r.sec;
        end
        QCM_C_ZERO: begin
          d.prim = `QCM_COUNT_RST;
          d.sec  = `QCM_COUNT_RST;
        end
        QCM_C_PRESET: begin
          d.prim = r.preset;
          d.sec  = r.preset;
        end
        QCM_C_START: begin
          d.prim = r.preset;
          d.sec  = r.preset;
          d.run  = 1'b1;
        end
        default: begin
          d.run = r.run;
        end
      endcase
    end

    // rate option: rising edges of a and b per fixed window
    if (!r.setup3[`QCM_S3_RATE_BIT]) begin
      d.rate_tmr   = 32'h0;
      d.rate_a_cnt = 32'h0;
      d.rate_b_cnt = 32'h0;
    end else if (r.rate_tmr >= RATE_CYCLES - 1) begin
      d.rate_a     = r.rate_a_cnt + {31'h0, a_rise};
      d.rate_b     = r.rate_b_cnt + {31'h0, b_rise};
      d.rate_tmr   = 32'h0;
      d.rate_a_cnt = 32'h0;
      d.rate_b_cnt = 32'h0;
    end else begin
      d.rate_tmr   = r.rate_tmr + 32'h1;
      d.rate_a_cnt = r.rate_a_cnt + {31'h0, a_rise};
      d.rate_b_cnt = r.rate_b_cnt + {31'h0, b_rise};
    end

    // relay compare: selected counter at or above its setpoint
    rly_want[0] = ($signed(pick(r.setup2[`QCM_S2_SRC_LSB +: 2], r)) >=
                   $signed(r.setpt5)) ^ r.setup2[`QCM_S2_NC_LSB];
    rly_want[1] = ($signed(pick(r.setup2[`QCM_S2_SRC_LSB + 2 +: 2], r)) >=
                   $signed(r.setpt6)) ^ r.setup2[`QCM_S2_NC_LSB + 1];

    // each relay follows only after its demand held for the response time
    for (int i = 0; i < 2; i++) begin
      if (rly_want[i] == r.rly_on[i]) begin
        d.rly_tmr[i] = 32'h0;
      end else if (r.rly_tmr[i] >= RLY_CYCLES - 1) begin
        d.rly_on[i]  = rly_want[i];
        d.rly_tmr[i] = 32'h0;
      end else begin
        d.rly_tmr[i] = r.rly_tmr[i] + 32'h1;
      end
    end

    // register writes
    if (wr_i) begin
      case (addr_i)
        `QCM_REG_SETUP1: begin
          d.setup1 = wdata_i;
          d.run    = (wdata_i[`QCM_S1_C_LSB +: 3] != QCM_C_START);
        end
        `QCM_REG_SETUP2: d.setup2 = wdata_i;
        `QCM_REG_SETUP3: d.setup3 = wdata_i;
        `QCM_REG_SETPT5: d.setpt5 = wdata_i;
        `QCM_REG_SETPT6: d.setpt6 = wdata_i;
        `QCM_REG_PRESET: d.preset = wdata_i;
        default:         d.setup1 = d.setup1;
      endcase
    end

    // register reads, data valid in the following cycle only
    d.rdata = 32'h0;
    if (rd_i) begin
      case (addr_i)
        `QCM_REG_SETUP1:    d.rdata = r.setup1;
        `QCM_REG_SETUP2:    d.rdata = r.setup2;
        `QCM_REG_SETUP3:    d.rdata = r.setup3;
        `QCM_REG_DISP_CH1:
          d.rdata = pick(r.setup1[`QCM_S1_CH_LSB +: 2], r);
        `QCM_REG_DISP_CH2:
          d.rdata = pick(r.setup1[`QCM_S1_CH_LSB + 2 +: 2], r);
        `QCM_REG_DISP_CH3:
          d.rdata = pick(r.setup1[`QCM_S1_CH_LSB + 4 +: 2], r);
        `QCM_REG_DISP_CH4:
          d.rdata = pick(r.setup1[`QCM_S1_CH_LSB + 6 +: 2], r);
        `QCM_REG_SETPT5:    d.rdata = r.setpt5;
        `QCM_REG_SETPT6:    d.rdata = r.setpt6;
        `QCM_REG_PRESET:    d.rdata = r.preset;
        `QCM_REG_PRIMARY:   d.rdata = r.prim;
        `QCM_REG_SECONDARY: d.rdata = r.sec;
        `QCM_REG_CAP_PRI:   d.rdata = r.cap_p;
        `QCM_REG_CAP_SEC:   d.rdata = r.cap_s;
        `QCM_REG_GATE:      d.rdata = r.gate;
        `QCM_REG_C_COUNT:   d.rdata = r.ccnt;
        `QCM_REG_RATE_A:    d.rdata = r.rate_a;
        `QCM_REG_RATE_B:    d.rdata = r.rate_b;
        default:            d.rdata = 32'h0;         // unmapped reads zero
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // all counters and setups clear, counting runs from reset
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      r     <= '0;
      r.run <= 1'b1;
    end else begin
      r <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata_o            = r.rdata;
  assign relay_one_output_o = r.rly_on[0];
  assign relay_two_output_o = r.rly_on[1];

endmodule // qcm_top

`default_nettype wire

// *** verif/qcm_enc_model.sv ***
/*
  encoder model: drives the a, b, c pins as a shaft encoder would.
  assumes its tasks are called by the bench on the module clock.
*/
`timescale 1ns/1ps
`default_nettype none

module qcm_enc_model (
  // clock
  input  wire logic       clk_i,
  // pins: c, b, a
  output var  logic [2:0] pins_o
);
  // ********
  // pin drivers
  // ********
  logic [1:0] ph;  // gray phase of a and b
  initial begin
    pins_o = 3'h0;
    ph = 2'h0;
  end
  // move one pin to a level, then let it settle
  task automatic set(input int i, input bit v);
    @(posedge clk_i);
    pins_o[i] <= v;
    repeat (6) @(posedge clk_i);
  endtask
  // pulse one pin high for w cycles, then rest
  task automatic pulse(input int i, input int w);
    @(posedge clk_i);
    pins_o[i] <= 1'b1;
    repeat (w) @(posedge clk_i);
    pins_o[i] <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
  // one encoder cycle: a moves first going down, b first going up
  task automatic turn(input bit up);
    repeat (4) begin
      ph = up ? ph - 2'h1 : ph + 2'h1;
      @(posedge clk_i);
      pins_o[1:0] <= {ph[1], ph[1] ^ ph[0]};
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule // qcm_enc_model

`default_nettype wire

// *** verif/qcm_top_sva.sv ***
/*
  checker of the quadrature counter module, watching its top ports.
  assumes it is bound into qcm_top with the same relay count.
*/
`timescale 1ns/1ps
`default_nettype none
`include "qcm_map.svh"

module qcm_top_sva #(
  parameter int unsigned RLY_CYCLES = 8
) (
  // clock and reset
  input wire logic                  ref_clk_i,
  input wire logic                  reset_n_i,
  // pins
  input wire logic                  enc_a_i,
  input wire logic                  enc_b_i,
  input wire logic                  enc_c_i,
  // register port
  input wire qcm_pkg::qcm_addr_type addr_i,
  input wire qcm_pkg::qcm_word_type wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire qcm_pkg::qcm_word_type rdata_o,
  // relays
  input wire logic                  relay_one_output_o,
  input wire logic                  relay_two_output_o
);
  import qcm_pkg::*;
  logic [15:0] r1_cnt;
  logic [15:0] r2_cnt;
  logic [3:0]  quiet;
  logic [2:0]  pins_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ********
  // helper counts
  // ********
  // cycles since each relay moved and since the pins last moved
  always_ff @(posedge ref_clk_i) begin
    pins_q <= {enc_c_i, enc_b_i, enc_a_i};
    if (!reset_n_i || $changed(relay_one_output_o))
      r1_cnt <= 16'h0;
    else if (r1_cnt != 16'hffff)
      r1_cnt <= r1_cnt + 16'h1;
    if (!reset_n_i || $changed(relay_two_output_o))
      r2_cnt <= 16'h0;
    else if (r2_cnt != 16'hffff)
      r2_cnt <= r2_cnt + 16'h1;
    if (!reset_n_i || pins_q != {enc_c_i, enc_b_i, enc_a_i})
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end
  // ********
  // assertions
  // ********
  sequence s_wr(a);
    wr_i && addr_i == a;
  endsequence
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  a_rdata_idle : assert property (
    !rd_i |=> rdata_o == 32'h0) else $error("read data not idle");
  a_unmapped_zero : assert property (
    rd_i && addr_i > 5'h11 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_setpt5_back : assert property (
    s_wr(`QCM_REG_SETPT5) ##2 s_rd(`QCM_REG_SETPT5)
    |=> rdata_o == $past(wdata_i, 3)) else $error("setpoint 5 lost");
  a_setpt6_back : assert property (
    s_wr(`QCM_REG_SETPT6) ##2 s_rd(`QCM_REG_SETPT6)
    |=> rdata_o == $past(wdata_i, 3)) else $error("setpoint 6 lost");
  a_primary_hold : assert property (
    (quiet >= 4'hc && rd_i && addr_i == `QCM_REG_PRIMARY)
    ##2 s_rd(`QCM_REG_PRIMARY) |=> rdata_o == $past(rdata_o, 2))
    else $error("primary moved without pin edges");
  a_relay1_space : assert property (
    $changed(relay_one_output_o) |-> r1_cnt >= RLY_CYCLES - 1)
    else $error("relay one switched too soon");
  a_relay2_space : assert property (
    $changed(relay_two_output_o) |-> r2_cnt >= RLY_CYCLES - 1)
    else $error("relay two switched too soon");
  a_relay_reset : assert property (
    $rose(reset_n_i) |-> !relay_one_output_o && !relay_two_output_o)
    else $error("relay on out of reset");
endmodule // qcm_top_sva

bind qcm_top qcm_top_sva #(.RLY_CYCLES(RLY_CYCLES)) qcm_top_sva_i (
  .ref_clk_i, .reset_n_i, .enc_a_i, .enc_b_i, .enc_c_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .relay_one_output_o, .relay_two_output_o);

`default_nettype wire

// *** verif/tb_qcm_top.sv ***
/*
  self-checking bench of the quadrature counter module.
  assumes the encoder model and the bound checker alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_qcm_top;
  import qcm_pkg::*;
  logic         ref_clk_i;
  logic         reset_n_i;
  logic [2:0]   pins;
  qcm_addr_type addr;
  qcm_word_type wdata;
  qcm_word_type rdata;
  logic         wr;
  logic         rd;
  logic         rly1;
  logic         rly2;
  int           n_mismatch;
  int           num_checks;
  int           nc;
  qcm_addr_type ra[9] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h08, 5'h09,
                          5'h0a, 5'h0f, 5'h1f};
  // mode, a pulses, b pulses, b held high, primary, secondary
  int           cm[4][6] = '{'{3, 2, 3, 0, 5, 0}, '{4, 3, 1, 0, 2, 0},
                             '{5, 2, 3, 0, 2, 3}, '{6, 3, 0, 1, -3, 0}};
  qcm_enc_model qcm_enc_model_i (.clk_i(ref_clk_i), .pins_o(pins));
  qcm_top #(.DEB_CYCLES(4), .RLY_CYCLES(8), .RATE_CYCLES(64)) qcm_top_i (
    .ref_clk_i, .reset_n_i, .enc_a_i(pins[0]), .enc_b_i(pins[1]),
    .enc_c_i(pins[2]), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .relay_one_output_o(rly1),
    .relay_two_output_o(rly2));
  // ********
  // tasks
  // ********
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input qcm_word_type seen, input qcm_word_type exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input qcm_addr_type a, input qcm_word_type d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  // read one word and compare it in the cycle it stands
  task automatic rc(input qcm_addr_type a, input qcm_word_type exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // display sources: ch1 primary, ch2 secondary, ch3 capture, ch4 primary
  task automatic setm(input int m, input int r);
    wr_reg(5'h00, 32'h0000_0900 | 32'(r << 3) | 32'(m));
  endtask
  task automatic cpulse;
    qcm_enc_model_i.pulse(2, 3);
    nc++;
  endtask
  task automatic zero(input int m);
    setm(m, 3);
    cpulse();
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // ********
  // clock, watchdog and main sequence
  // ********
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    conclude();
  end
  initial begin
    reset_n_i = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    nc = 0;
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    foreach (ra[i]) rc(ra[i], 32'h0);
    wr_reg(5'h07, 32'h0000_0002);
    rc(5'h07, 32'h0000_0002);
    wr_reg(5'h08, 32'h0000_0002);
    rc(5'h08, 32'h0000_0002);
    wr_reg(5'h0a, 32'h5a5a_5a5a);
    rc(5'h0a, 32'h0);
    for (int m = 0; m < 3; m++) begin
      zero(m);
      repeat (3) qcm_enc_model_i.turn(1'b0);
      rc(5'h0a, -(32'h3 << m));
      repeat (5) qcm_enc_model_i.turn(1'b1);
      rc(5'h0a, 32'h2 << m);
    end
    foreach (cm[i]) begin
      zero(cm[i][0]);
      qcm_enc_model_i.set(1, cm[i][3]);
      repeat (cm[i][1]) qcm_enc_model_i.pulse(0, 3);
      repeat (cm[i][2]) qcm_enc_model_i.pulse(1, 3);
      rc(5'h0a, 32'(cm[i][4]));
      rc(5'h0b, 32'(cm[i][5]));
      qcm_enc_model_i.set(1, 1'b0);
    end
    zero(5);
    setm(5, 1);
    repeat (3) qcm_enc_model_i.pulse(0, 3);
    cpulse();
    qcm_enc_model_i.pulse(0, 3);
    rc(5'h0c, 32'h3);
    rc(5'h0a, 32'h4);
    rc(5'h0a, 32'h4);
    rc(5'h02, 32'h4);
    rc(5'h04, 32'h0);
    rc(5'h05, 32'h3);
    rc(5'h06, 32'h4);
    setm(5, 6);
    cpulse();
    rc(5'h0a, 32'h4);
    rc(5'h0f, 32'(nc));
    wr_reg(5'h01, 32'h0000_0020);
    settle(12);
    chk({30'h0, rly2, rly1}, 32'h1);
    wr_reg(5'h01, 32'h0000_0022);
    wr_reg(5'h07, 32'h0000_0004);
    wr_reg(5'h08, 32'h0000_0005);
    settle(3);
    chk({30'h0, rly2, rly1}, 32'h1);
    settle(12);
    chk({30'h0, rly2, rly1}, 32'h2);
    wr_reg(5'h03, 32'h0000_0001);
    qcm_enc_model_i.pulse(0, 2);
    rc(5'h0a, 32'h4);
    qcm_enc_model_i.pulse(0, 10);
    rc(5'h0a, 32'h5);
    // rate window opens at the setup write: two a and one b rising edge
    wr_reg(5'h03, 32'h0000_0002);
    repeat (2) qcm_enc_model_i.pulse(0, 3);
    qcm_enc_model_i.pulse(1, 3);
    settle(30);
    rc(5'h10, 32'h2);
    rc(5'h11, 32'h1);
    // secondary capture, then preset, start and gate roles
    setm(5, 1);
    cpulse();
    rc(5'h0d, 32'h1);
    wr_reg(5'h09, 32'h0000_0010);
    setm(5, 4);
    cpulse();
    rc(5'h0b, 32'h10);
    setm(5, 5);
    qcm_enc_model_i.pulse(0, 3);
    rc(5'h0a, 32'h10);
    cpulse();
    qcm_enc_model_i.pulse(0, 3);
    rc(5'h0a, 32'h11);
    setm(5, 2);
    qcm_enc_model_i.pulse(0, 3);
    qcm_enc_model_i.set(2, 1'b1);
    repeat (2) qcm_enc_model_i.pulse(0, 3);
    qcm_enc_model_i.set(2, 1'b0);
    rc(5'h0e, 32'h2);
    rc(5'h0a, 32'h13);
    conclude();
  end
endmodule // tb_qcm_top

`default_nettype wire
